//--- verilog/epr_pkg.sv
// Constants for the partner ability, expansion and vendor mode registers.
package epr_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] OFS_LP_ABILITY = 5'h05;
  localparam logic [4:0] OFS_AN_EXPANSION = 5'h06;
  localparam logic [4:0] OFS_VENDOR_MODE = 5'h10;
  localparam logic [15:0] RST_LP_ABILITY = 16'h0000;
  localparam logic [15:0] RST_AN_EXPANSION = 16'h0000;
  localparam logic [15:0] RST_VENDOR_MODE = 16'h0140;
  // Partner ability fields.
  localparam int LP_NEXT_PAGE = 15;
  localparam int LP_ACK = 14;
  localparam int LP_REMOTE_FAULT = 13;
  localparam int LP_TECH_HI = 12;
  localparam int LP_TECH_LO = 5;
  localparam int LP_TECH_10HD = 5;
  localparam int LP_SEL_HI = 4;
  localparam logic [4:0] SEL_8023 = 5'h01;
  localparam logic [4:0] SEL_8029 = 5'h02;
  localparam logic [4:0] SEL_8025 = 5'h03;
  localparam logic [4:0] SEL_1394 = 5'h04;
  // Expansion fields.
  localparam int EXP_LP_AN_ABLE = 0;
  localparam int EXP_PAGE_RCVD = 1;
  localparam int EXP_LOCAL_NEXT_PAGE = 2;
  localparam int EXP_LP_NEXT_PAGE = 3;
  localparam int EXP_PD_FAULT = 4;
  // Vendor mode fields.
  localparam int VM_REPEATER = 15;
  localparam int VM_IRQ_POL = 14;
  localparam int VM_TX_HIZ = 12;
  localparam int VM_SQE_INHIBIT = 11;
  localparam int VM_NAT_LOOP = 10;
  localparam int VM_AUTO_POL_DIS = 5;
  localparam int VM_RX_POL = 4;
  localparam int VM_PCS_BYPASS = 1;
  localparam int VM_RXCLK_GATE = 0;
  localparam logic [15:0] VM_WR_MASK = 16'hdc33;
  localparam logic [15:0] VM_FIXED_ONES = 16'h0140;
endpackage

//--- verilog/epr_partner_capture.sv
// Holds the partner base page taken during auto-negotiation.
`timescale 1ns/10ps
`default_nettype none
module epr_partner_capture (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic page_valid, // One-cycle strobe: base page received.
  input wire logic [15:0] page_word, // Received base page.
  input wire logic an_restart, // Negotiation restart pulse.
  output logic [15:0] lp_ability, // Captured partner abilities.
  output logic page_seen, // One-cycle pulse after a capture.
  output logic sel_8023 // Partner selector names IEEE 802.3.
);
  import epr_pkg::*;

  logic [15:0] next_lp_ability;
  logic next_page_seen;
  logic next_sel_8023;

  always_comb begin
    next_lp_ability = lp_ability;
    next_page_seen = 1'b0;
    next_sel_8023 = sel_8023;
    if (page_valid) begin
      // Upper technology bits are kept as sent even though no such mode exists here.
      next_lp_ability = page_word;
      next_lp_ability[LP_ACK] = 1'b1;
      next_page_seen = 1'b1;
      next_sel_8023 = (page_word[LP_SEL_HI:0] == SEL_8023);
    end else if (an_restart) begin
      next_lp_ability = RST_LP_ABILITY;
      next_sel_8023 = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lp_ability <= RST_LP_ABILITY;
      page_seen <= 1'b0;
      sel_8023 <= 1'b0;
    end else begin
      lp_ability <= next_lp_ability;
      page_seen <= next_page_seen;
      sel_8023 <= next_sel_8023;
    end
  end
endmodule
`default_nettype wire

//--- verilog/epr_mode_ctrl.sv
// Turns the vendor mode bits into registered PHY control levels.
`timescale 1ns/10ps
`default_nettype none
module epr_mode_ctrl (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [15:0] vend, // Stored vendor mode bits.
  input wire logic an_enable, // Auto-negotiation on.
  input wire logic speed_100, // 100BASE-TX selected.
  input wire logic duplex_req, // Full duplex requested.
  input wire logic loopback, // Loopback selected.
  input wire logic rx_active, // Receive activity.
  input wire logic tx_active, // Transmit activity.
  input wire logic pol_reversed, // Receive pair found reversed.
  input wire logic irq_req, // Internal interrupt request.
  output logic full_duplex, // Full-duplex operation.
  output logic carrier_sense, // Carrier sense.
  output logic irq_pin, // Interrupt at the chosen level.
  output logic rx_invert, // Invert receive data.
  output logic pcs_bypass, // Bypass coding and scrambler.
  output logic rx_clk_en, // Receive clock running.
  output logic tx_hiz, // Transmit pins released.
  output logic sqe_inhibit, // SQE test off.
  output logic nat_loop // 10BASE-T natural loopback.
);
  import epr_pkg::*;

  logic next_fd, next_cs, next_irq, next_inv, next_byp, next_rck;

  always_comb begin
    next_fd = duplex_req && !vend[VM_REPEATER];
    next_cs = vend[VM_REPEATER] ? rx_active : (rx_active || tx_active);
    next_irq = vend[VM_IRQ_POL] ? irq_req : !irq_req;
    if (vend[VM_AUTO_POL_DIS]) begin
      next_inv = vend[VM_RX_POL];
    end else begin
      next_inv = pol_reversed && !speed_100;
    end
    next_byp = vend[VM_PCS_BYPASS] && !an_enable && speed_100;
    // Loopback keeps the clock alive so looped data is never starved.
    next_rck = !(vend[VM_RXCLK_GATE] && speed_100 && !loopback && !rx_active);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      full_duplex <= 1'b0;
      carrier_sense <= 1'b0;
      irq_pin <= 1'b1;
      rx_invert <= 1'b0;
      pcs_bypass <= 1'b0;
      rx_clk_en <= 1'b1;
      tx_hiz <= 1'b0;
      sqe_inhibit <= 1'b0;
      nat_loop <= 1'b0;
    end else begin
      full_duplex <= next_fd;
      carrier_sense <= next_cs;
      irq_pin <= next_irq;
      rx_invert <= next_inv;
      pcs_bypass <= next_byp;
      rx_clk_en <= next_rck;
      tx_hiz <= vend[VM_TX_HIZ];
      sqe_inhibit <= vend[VM_SQE_INHIBIT];
      nat_loop <= vend[VM_NAT_LOOP];
    end
  end
endmodule
`default_nettype wire

//--- verilog/epr_regs.sv
// Partner ability, expansion and vendor mode registers of the PHY management port.
//
// Functional notes
// - Partner ability register is read-only, holds captured partner page, resets to zero.
// - Bit 15 reads one when the partner offers next-page exchange.
// - Bit 14 sets once the partner's base page was received correctly.
// - Bit 13 carries the partner's remote-fault indication.
// - Bits 12:5 hold the partner technology field, same meanings as own advertisement.
// - Technology bits 12:9 are stored as received though unsupported here.
// - Bits 4:0 hold the partner selector; only 0x01 means IEEE 802.3.
// - Read-only expansion register, reset zero, reports both ends' negotiation abilities.
// - Vendor mode register, reset 0x0140, sets the PHY's own modes.
// - Technology bit 5 is 10BASE-T half duplex; higher bits faster modes.
// - Vendor bit 5 disables auto polarity; clear means reversed 10BASE-T input inverts.
// - Vendor bit 1 bypasses coding and scrambler, only 100BASE-TX without negotiation.
// - Vendor bit 0 gates idle 100BASE-TX receive clock, never during loopback.
`timescale 1ns/10ps
`default_nettype none
module epr_regs #(
  parameter bit LOCAL_NEXT_PAGE = 1'b0 // Own next-page ability shown in expansion.
) (
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [epr_pkg::ADDR_W-1:0] mgmt_addr, // Management register address.
  input wire logic mgmt_wr, // One-cycle write strobe.
  input wire logic mgmt_rd, // One-cycle read strobe.
  input wire logic [epr_pkg::DATA_W-1:0] mgmt_wdata, // Write data.
  output logic [epr_pkg::DATA_W-1:0] mgmt_rdata, // Read data, held until next read.
  output logic mgmt_rvalid, // One-cycle pulse with read data.
  input wire logic lp_page_valid, // Base page received strobe.
  input wire logic [15:0] lp_page, // Received base page.
  input wire logic an_restart, // Negotiation restart pulse.
  input wire logic an_enable, // Auto-negotiation on.
  input wire logic lp_an_able, // Partner takes part in negotiation.
  input wire logic pd_fault, // Parallel detection fault pulse.
  input wire logic speed_100, // 100BASE-TX selected.
  input wire logic duplex_req, // Full duplex requested.
  input wire logic loopback, // Loopback selected.
  input wire logic rx_active, // Receive activity.
  input wire logic tx_active, // Transmit activity.
  input wire logic pol_reversed, // Receive pair found reversed.
  input wire logic irq_req, // Internal interrupt request.
  output logic lp_sel_8023, // Partner speaks IEEE 802.3.
  output logic lp_10hd, // Partner offers 10BASE-T half duplex.
  output logic full_duplex, // Full-duplex operation.
  output logic carrier_sense, // Carrier sense.
  output logic irq_pin, // Interrupt at the chosen level.
  output logic rx_invert, // Invert receive data.
  output logic pcs_bypass, // Bypass coding and scrambler.
  output logic rx_clk_en, // Receive clock running.
  output logic tx_hiz, // Transmit pins released.
  output logic sqe_inhibit, // SQE test off.
  output logic nat_loop // 10BASE-T natural loopback.
);
  import epr_pkg::*;

  logic [15:0] lp_ability;
  logic page_seen;
  logic [15:0] vend;
  logic [15:0] next_vend;
  logic page_rcvd, pd_flag;
  logic next_page_rcvd, next_pd_flag;
  logic [15:0] exp_word, vend_view;
  logic [15:0] next_rdata;
  logic next_rvalid, next_10hd;
  logic rd_exp;

  epr_partner_capture u_capture (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .page_valid(lp_page_valid),
    .page_word(lp_page),
    .an_restart(an_restart),
    .lp_ability(lp_ability),
    .page_seen(page_seen),
    .sel_8023(lp_sel_8023)
  );

  epr_mode_ctrl u_mode (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .vend(vend),
    .an_enable(an_enable),
    .speed_100(speed_100),
    .duplex_req(duplex_req),
    .loopback(loopback),
    .rx_active(rx_active),
    .tx_active(tx_active),
    .pol_reversed(pol_reversed),
    .irq_req(irq_req),
    .full_duplex(full_duplex),
    .carrier_sense(carrier_sense),
    .irq_pin(irq_pin),
    .rx_invert(rx_invert),
    .pcs_bypass(pcs_bypass),
    .rx_clk_en(rx_clk_en),
    .tx_hiz(tx_hiz),
    .sqe_inhibit(sqe_inhibit),
    .nat_loop(nat_loop)
  );

  assign rd_exp = mgmt_rd && (mgmt_addr == OFS_AN_EXPANSION);

  // Expansion view; capability bits follow their sources live.
  always_comb begin
    exp_word = RST_AN_EXPANSION;
    exp_word[EXP_LP_AN_ABLE] = lp_an_able;
    exp_word[EXP_PAGE_RCVD] = page_rcvd;
    exp_word[EXP_LOCAL_NEXT_PAGE] = LOCAL_NEXT_PAGE;
    exp_word[EXP_LP_NEXT_PAGE] = lp_ability[LP_NEXT_PAGE] && lp_ability[LP_ACK];
    exp_word[EXP_PD_FAULT] = pd_flag;
  end

  // Sticky expansion flags clear on read; a new event in that cycle still wins.
  always_comb begin
    next_page_rcvd = page_rcvd;
    next_pd_flag = pd_flag;
    if (rd_exp) begin
      next_page_rcvd = 1'b0;
      next_pd_flag = 1'b0;
    end
    if (page_seen) begin
      next_page_rcvd = 1'b1;
    end
    if (pd_fault) begin
      next_pd_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      page_rcvd <= 1'b0;
      pd_flag <= 1'b0;
    end else begin
      page_rcvd <= next_page_rcvd;
      pd_flag <= next_pd_flag;
    end
  end

  // Vendor mode writes touch only writable bits; the fixed pattern cannot be lost.
  always_comb begin
    next_vend = vend;
    if (mgmt_wr && (mgmt_addr == OFS_VENDOR_MODE)) begin
      next_vend = (mgmt_wdata & VM_WR_MASK) | VM_FIXED_ONES;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vend <= RST_VENDOR_MODE;
    end else begin
      vend <= next_vend;
    end
  end

  // With auto polarity active, the polarity bit reports the detector instead.
  always_comb begin
    vend_view = vend;
    if (!vend[VM_AUTO_POL_DIS]) begin
      vend_view[VM_RX_POL] = rx_invert;
    end
  end

  // Read port; the two partner registers ignore writes entirely.
  always_comb begin
    next_rdata = mgmt_rdata;
    next_rvalid = mgmt_rd;
    if (mgmt_rd) begin
      if (mgmt_addr == OFS_LP_ABILITY) begin
        next_rdata = lp_ability;
      end else if (mgmt_addr == OFS_AN_EXPANSION) begin
        next_rdata = exp_word;
      end else if (mgmt_addr == OFS_VENDOR_MODE) begin
        next_rdata = vend_view;
      end else begin
        next_rdata = 16'h0000;
      end
    end
    next_10hd = lp_ability[LP_TECH_10HD] && lp_ability[LP_ACK];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mgmt_rdata <= 16'h0000;
      mgmt_rvalid <= 1'b0;
      lp_10hd <= 1'b0;
    end else begin
      mgmt_rdata <= next_rdata;
      mgmt_rvalid <= next_rvalid;
      lp_10hd <= next_10hd;
    end
  end

  chk_ack_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
    lp_page_valid |=> lp_ability[LP_ACK] ##1 page_rcvd)
    else $error("ack bit or page flag not set after capture");

  chk_next_page_copy: assert property (@(posedge clk_sys) disable iff (!rstn)
    lp_page_valid |=> lp_ability[LP_NEXT_PAGE] == $past(lp_page[LP_NEXT_PAGE]))
    else $error("next page bit differs from received page");

  chk_fault_copy: assert property (@(posedge clk_sys) disable iff (!rstn)
    lp_page_valid |=> lp_ability[LP_REMOTE_FAULT] == $past(lp_page[LP_REMOTE_FAULT]))
    else $error("remote fault bit differs from received page");

  chk_tech_copy: assert property (@(posedge clk_sys) disable iff (!rstn)
    lp_page_valid |=> lp_ability[LP_TECH_HI:LP_TECH_LO] == $past(lp_page[12:5]))
    else $error("technology field differs from received page");

  chk_sel_copy: assert property (@(posedge clk_sys) disable iff (!rstn)
    lp_page_valid |=> (lp_ability[4:0] == $past(lp_page[4:0]))
      && (lp_sel_8023 == ($past(lp_page[4:0]) == SEL_8023)))
    else $error("selector field or decode wrong");

  chk_10hd_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    lp_page_valid ##1 !lp_page_valid |=> lp_10hd == $past(lp_page[LP_TECH_10HD], 2))
    else $error("10BASE-T half duplex flag wrong");

  chk_lp_readonly: assert property (@(posedge clk_sys) disable iff (!rstn)
    mgmt_wr && !lp_page_valid && !an_restart |=> $stable(lp_ability))
    else $error("partner register changed without a page");

  chk_exp_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_exp && !page_seen && !pd_fault |=> !page_rcvd && !pd_flag)
    else $error("expansion flags not cleared by read");

  chk_vend_fixed: assert property (@(posedge clk_sys) disable iff (!rstn)
    (vend & ~VM_WR_MASK) == VM_FIXED_ONES)
    else $error("fixed vendor bits disturbed");

  chk_autopol_invert: assert property (@(posedge clk_sys) disable iff (!rstn)
    !vend[VM_AUTO_POL_DIS] && !speed_100 |=> rx_invert == $past(pol_reversed))
    else $error("auto polarity not followed");

  chk_bypass_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    pcs_bypass |-> $past(vend[VM_PCS_BYPASS] && !an_enable && speed_100))
    else $error("coding bypass outside allowed mode");

  chk_rxclk_loop: assert property (@(posedge clk_sys) disable iff (!rstn)
    loopback || !speed_100 |=> rx_clk_en)
    else $error("receive clock gated in loopback");

  chk_repeater_duplex: assert property (@(posedge clk_sys) disable iff (!rstn)
    vend[VM_REPEATER] |=> !full_duplex && (carrier_sense == $past(rx_active)))
    else $error("repeater mode allowed duplex or wrong carrier");

  chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> irq_pin == ($past(vend[VM_IRQ_POL]) ? $past(irq_req) : !$past(irq_req)))
    else $error("interrupt level wrong for polarity");

  // Every output is a flop, so each check below looks one cycle after its cause.
  // A read therefore shows the state sampled at the strobe, not the state after it.
  chk_lp_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    mgmt_rd && (mgmt_addr == OFS_LP_ABILITY)
      |=> mgmt_rvalid && (mgmt_rdata == $past(lp_ability)))
    else $error("partner register read returned wrong word");

  chk_exp_layout: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_exp |=> (mgmt_rdata[EXP_LP_AN_ABLE] == $past(lp_an_able)) && (mgmt_rdata[15:5] == 11'h000))
    else $error("expansion read layout wrong");

  chk_vend_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    mgmt_rd && (mgmt_addr == OFS_VENDOR_MODE) && vend[VM_AUTO_POL_DIS]
      |=> mgmt_rdata == $past(vend))
    else $error("vendor register read returned wrong word");

  chk_pd_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    pd_fault |=> pd_flag)
    else $error("parallel detection fault not recorded");

  chk_forced_pol: assert property (@(posedge clk_sys) disable iff (!rstn)
    vend[VM_AUTO_POL_DIS] |=> rx_invert == $past(vend[VM_RX_POL]))
    else $error("forced polarity not applied");

  chk_rxclk_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    vend[VM_RXCLK_GATE] && speed_100 && !loopback && !rx_active |=> !rx_clk_en)
    else $error("idle receive clock not gated");

  chk_restart_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    an_restart && !lp_page_valid |=> lp_ability == RST_LP_ABILITY)
    else $error("partner register not cleared by restart");

  chk_upper_tech: assert property (@(posedge clk_sys) disable iff (!rstn)
    lp_page_valid |=> lp_ability[12:9] == $past(lp_page[12:9]))
    else $error("upper technology bits not kept as received");

  chk_duplex_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
    !vend[VM_REPEATER] |=> full_duplex == $past(duplex_req))
    else $error("full duplex not following request");

  cov_capture: cover property (@(posedge clk_sys) disable iff (!rstn)
    lp_page_valid ##1 lp_sel_8023);

  cov_vend_write: cover property (@(posedge clk_sys) disable iff (!rstn)
    mgmt_wr && (mgmt_addr == OFS_VENDOR_MODE) ##1 vend[VM_REPEATER]);

  cov_exp_read: cover property (@(posedge clk_sys) disable iff (!rstn)
    page_rcvd && rd_exp ##1 mgmt_rvalid);

  cov_rxclk_gated: cover property (@(posedge clk_sys) disable iff (!rstn)
    !rx_clk_en);

  // A fault flag read back proves the clear-on-read path was exercised.
  cov_pd_read: cover property (@(posedge clk_sys) disable iff (!rstn)
    pd_flag && rd_exp);
endmodule
`default_nettype wire

//--- tb/epr_link_partner.sv
// Behavioural model of the remote link partner that delivers base pages.
`timescale 1ns/10ps
`default_nettype none
module epr_link_partner (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  output logic lp_page_valid, // One-cycle base page strobe.
  output logic [15:0] lp_page, // Base page word.
  output logic lp_an_able // Partner takes part in negotiation.
);
  initial begin
    lp_page_valid = 1'b0;
    lp_page = 16'h0000;
    lp_an_able = 1'b0;
  end
  // The word is inverted after the strobe, so a late sample cannot pass by luck.
  task automatic send_page(input logic [15:0] word, input int gap);
    wait (rstn);
    repeat (gap + 1) @(posedge clk_sys);
    lp_page_valid <= 1'b1;
    lp_page <= word;
    @(posedge clk_sys);
    lp_page_valid <= 1'b0;
    lp_page <= ~word;
  endtask
  task automatic set_able(input logic able);
    @(posedge clk_sys);
    lp_an_able <= able;
  endtask
endmodule
`default_nettype wire

//--- tb/test_phy_autoneg_partner_and_vendor_regs.sv
// Self-checking testbench for the partner ability, expansion and vendor mode registers.
`timescale 1ns/10ps
`default_nettype none
module test_phy_autoneg_partner_and_vendor_regs;
  import epr_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] mgmt_addr = 5'h00;
  logic mgmt_wr = 1'b0;
  logic mgmt_rd = 1'b0;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [15:0] mgmt_rdata;
  logic mgmt_rvalid;
  logic lp_page_valid;
  logic [15:0] lp_page;
  logic lp_an_able;
  logic an_restart = 1'b0;
  logic an_enable = 1'b0;
  logic pd_fault = 1'b0;
  logic speed_100 = 1'b0;
  logic duplex_req = 1'b0;
  logic loopback = 1'b0;
  logic rx_active = 1'b0;
  logic tx_active = 1'b0;
  logic pol_reversed = 1'b0;
  logic irq_req = 1'b0;
  logic lp_sel_8023, lp_10hd, full_duplex, carrier_sense, irq_pin, rx_invert;
  logic pcs_bypass, rx_clk_en, tx_hiz, sqe_inhibit, nat_loop;
  int n_mismatch = 0;
  int checks = 0;
  logic [4:0] sel_list [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1f};

  always #2 clk_sys = ~clk_sys;

  epr_link_partner i_epr_link_partner (.clk_sys(clk_sys), .rstn(rstn),
    .lp_page_valid(lp_page_valid), .lp_page(lp_page), .lp_an_able(lp_an_able));

  epr_regs i_epr_regs (.clk_sys(clk_sys), .rstn(rstn), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .lp_page_valid(lp_page_valid), .lp_page(lp_page),
    .an_restart(an_restart), .an_enable(an_enable), .lp_an_able(lp_an_able),
    .pd_fault(pd_fault), .speed_100(speed_100), .duplex_req(duplex_req),
    .loopback(loopback), .rx_active(rx_active), .tx_active(tx_active),
    .pol_reversed(pol_reversed), .irq_req(irq_req), .lp_sel_8023(lp_sel_8023),
    .lp_10hd(lp_10hd), .full_duplex(full_duplex), .carrier_sense(carrier_sense),
    .irq_pin(irq_pin), .rx_invert(rx_invert), .pcs_bypass(pcs_bypass),
    .rx_clk_en(rx_clk_en), .tx_hiz(tx_hiz), .sqe_inhibit(sqe_inhibit),
    .nat_loop(nat_loop));

  task automatic final_report();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpb(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask

  // Reads answer exactly one cycle after the strobe is taken.
  task automatic reg_rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    mgmt_rd <= 1'b1;
    mgmt_addr <= a;
    @(posedge clk_sys);
    mgmt_rd <= 1'b0;
    #1;
    cmpb(mgmt_rvalid, 1'b1);
    cmp(mgmt_rdata, exp);
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    mgmt_wr <= 1'b1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge clk_sys);
    mgmt_wr <= 1'b0;
  endtask

  // Three edges cover the two-cycle path from a vendor write to the control outputs.
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic mode_wr(input logic [15:0] d);
    reg_wr(OFS_VENDOR_MODE, d);
    settle();
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    reg_rd(OFS_LP_ABILITY, RST_LP_ABILITY);
    reg_rd(OFS_AN_EXPANSION, RST_AN_EXPANSION);
    reg_rd(OFS_VENDOR_MODE, RST_VENDOR_MODE);
    reg_rd(5'h07, 16'h0000);
    reg_wr(OFS_LP_ABILITY, 16'hffff);
    reg_wr(OFS_AN_EXPANSION, 16'hffff);
    reg_rd(OFS_LP_ABILITY, 16'h0000);
    reg_rd(OFS_AN_EXPANSION, 16'h0000);
    // Selector codes with remote fault and the unsupported technology bits set.
    foreach (sel_list[i]) begin
      i_epr_link_partner.send_page({11'h1f0, sel_list[i]}, i % 3);
      settle();
      cmpb(lp_sel_8023, sel_list[i] == SEL_8023);
      cmpb(lp_10hd, 1'b0);
      reg_rd(OFS_LP_ABILITY, {11'h3f0, sel_list[i]});
    end
    i_epr_link_partner.set_able(1'b1);
    i_epr_link_partner.send_page(16'ha1e1, 0);
    settle();
    cmpb(lp_10hd, 1'b1);
    reg_rd(OFS_LP_ABILITY, 16'he1e1);
    reg_rd(OFS_AN_EXPANSION, 16'h000b);
    reg_rd(OFS_AN_EXPANSION, 16'h0009);
    @(posedge clk_sys);
    pd_fault <= 1'b1;
    @(posedge clk_sys);
    pd_fault <= 1'b0;
    reg_rd(OFS_AN_EXPANSION, 16'h0019);
    reg_rd(OFS_AN_EXPANSION, 16'h0009);
    @(posedge clk_sys);
    an_restart <= 1'b1;
    @(posedge clk_sys);
    an_restart <= 1'b0;
    reg_rd(OFS_LP_ABILITY, 16'h0000);
    // Vendor register: writable bits and fixed bits.
    reg_wr(OFS_VENDOR_MODE, 16'hffff);
    reg_rd(OFS_VENDOR_MODE, VM_WR_MASK | VM_FIXED_ONES);
    mode_wr(16'h0000);
    reg_rd(OFS_VENDOR_MODE, 16'h0140);
    // Repeater mode against duplex and carrier sense, then interrupt polarity.
    @(posedge clk_sys);
    duplex_req <= 1'b1;
    tx_active <= 1'b1;
    irq_req <= 1'b1;
    settle();
    cmpb(full_duplex, 1'b1);
    cmpb(carrier_sense, 1'b1);
    cmpb(irq_pin, 1'b0);
    mode_wr(16'h8000);
    cmpb(full_duplex, 1'b0);
    cmpb(carrier_sense, 1'b0);
    @(posedge clk_sys);
    rx_active <= 1'b1;
    settle();
    cmpb(carrier_sense, 1'b1);
    mode_wr(16'h4000);
    cmpb(irq_pin, 1'b1);
    @(posedge clk_sys);
    irq_req <= 1'b0;
    rx_active <= 1'b0;
    settle();
    cmpb(irq_pin, 1'b0);
    // Automatic polarity correction only in 10BASE-T.
    mode_wr(16'h0000);
    @(posedge clk_sys);
    pol_reversed <= 1'b1;
    settle();
    cmpb(rx_invert, 1'b1);
    reg_rd(OFS_VENDOR_MODE, 16'h0150);
    @(posedge clk_sys);
    speed_100 <= 1'b1;
    settle();
    cmpb(rx_invert, 1'b0);
    mode_wr(16'h0020);
    cmpb(rx_invert, 1'b0);
    mode_wr(16'h0030);
    cmpb(rx_invert, 1'b1);
    // Coding bypass needs negotiation off and 100BASE-TX.
    mode_wr(16'h0002);
    cmpb(pcs_bypass, 1'b1);
    @(posedge clk_sys);
    an_enable <= 1'b1;
    settle();
    cmpb(pcs_bypass, 1'b0);
    // Receive clock gating stops with no traffic and yields to loopback.
    mode_wr(16'h0001);
    cmpb(rx_clk_en, 1'b0);
    @(posedge clk_sys);
    loopback <= 1'b1;
    settle();
    cmpb(rx_clk_en, 1'b1);
    mode_wr(16'h1c00);
    cmp({13'h0000, tx_hiz, sqe_inhibit, nat_loop}, 16'h0007);
    // A reset in mid-run must bring the written register back to its reset value.
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    reg_rd(OFS_VENDOR_MODE, RST_VENDOR_MODE);
    reg_rd(OFS_LP_ABILITY, RST_LP_ABILITY);
    cmp({13'h0000, tx_hiz, sqe_inhibit, nat_loop}, 16'h0000);
    final_report();
  end

  // The whole sequence needs well under 1000 cycles.
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
